// ==== hdl/ifd_decoder.v ====
/*
 Instruction decoder with format and cycle sequencing.
 Assumes program memory presents one word per accepted fetch and the datapath
 reports conditional and skip outcomes in the cycle the instruction decodes.
*/
// Contract
// - Each single-word instruction is 24 bits with an 8-bit opcode and operand bits.
// - Double-word instructions take two words and the second word's top 8 bits are zero.
// - A second word decoded by itself executes as a no-operation.
// - Exactly three opcodes are two-word; all others are single-word.
// - Single-word ops take one cycle, or two when a test is true or the PC changes.
// - Branch, indirect call/jump, table access and returns take two or three cycles.
// - A taken skip costs two cycles over a one-word and three over a two-word target.
// - Double-word instructions complete in two cycles.
// - Working-register ops decode base, second source and destination with modifiers.
// - File-register ops decode a file address and a file-or-register-zero destination.
// - Bit ops take a register or file operand and a literal or base-held bit number.
// - Literal arithmetic uses the base source, a literal, and an optional destination.
// - Control ops decode a program address and table ops also an access mode.
`timescale 1ns/1ps
`include "ifd_consts.vh"

module ifd_decoder #(
   parameter [1:0] LONG_OP_CYCLES = `IFD_CYC_LONG_DEF
) (
   input wire i_mclk,
   input wire i_reset,
   input wire [23:0] i_fetch_word,
   input wire i_fetch_valid,
   output wire o_fetch_ready,
   input wire i_cond_true,
   input wire i_skip_taken,
   output reg o_exec_valid_q,
   output reg o_exec_nop_q,
   output reg o_second_word_q,
   output reg [7:0] o_opcode_q,
   output reg [15:0] o_operand_q,
   output reg [15:0] o_extension_q,
   output reg [2:0] o_category_q,
   output reg [1:0] o_cycles_q,
   output reg o_format_error_q,
   output wire [3:0] o_base_source_register,
   output wire [3:0] o_second_source_register,
   output wire [2:0] o_second_source_mode,
   output wire [3:0] o_destination_register,
   output wire [2:0] o_destination_mode,
   output wire [12:0] o_file_addr,
   output wire o_dest_is_working_register_zero,
   output wire [3:0] o_bit_pos,
   output wire o_bit_from_base,
   output wire [9:0] o_literal,
   output wire o_dest_separate,
   output wire [15:0] o_prog_addr,
   output wire [1:0] o_table_mode
);

   // ==========================================================
   // States
   localparam [3:0] ST_DECODE = 4'h1;
   localparam [3:0] ST_EXT = 4'h2;
   localparam [3:0] ST_FILL = 4'h4;
   localparam [3:0] ST_SKIP = 4'h8;

   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [1:0] fill_q;
   reg [1:0] fill_d;
   reg skip_two_q;
   reg skip_two_d;

   wire [7:0] opc = i_fetch_word[`IFD_OPC_HI:`IFD_OPC_LO];
   wire [2:0] cat;
   wire two_word;
   wire long_op;
   wire skip_op;
   wire cond_op;

   // ==========================================================
   // Classification of the word being offered
   ifd_class u_class (
      .i_opcode(opc),
      .o_category(cat),
      .o_two_word(two_word),
      .o_long_op(long_op),
      .o_skip_op(skip_op),
      .o_cond_op(cond_op),
      .o_table_op()
   );

   // Fields come from the held word so they stay aligned to the exec outputs.
   ifd_fields u_fields (
      .i_word({o_opcode_q, o_operand_q}),
      .i_category(o_category_q),
      .o_base_source_register(o_base_source_register),
      .o_second_source_register(o_second_source_register),
      .o_second_source_mode(o_second_source_mode),
      .o_destination_register(o_destination_register),
      .o_destination_mode(o_destination_mode),
      .o_file_addr(o_file_addr),
      .o_dest_is_working_register_zero(o_dest_is_working_register_zero),
      .o_bit_pos(o_bit_pos),
      .o_bit_from_base(o_bit_from_base),
      .o_literal(o_literal),
      .o_dest_separate(o_dest_separate),
      .o_prog_addr(o_prog_addr),
      .o_table_mode(o_table_mode)
   );

   // Every state but fill consumes a word; fill cycles are internal no-ops.
   assign o_fetch_ready = ~state_q[2];

   wire take = i_fetch_valid & o_fetch_ready;

   // ==========================================================
   // Sequencer
   always @* begin
      state_d = state_q;
      fill_d = fill_q;
      skip_two_d = skip_two_q;
      case (state_q)
         ST_DECODE: begin
            if (take) begin
               if (two_word) begin
                  state_d = ST_EXT;
               end else if (skip_op && i_skip_taken) begin
                  state_d = ST_SKIP;
               end else if (long_op) begin
                  fill_d = LONG_OP_CYCLES - `IFD_CYC_ONE;
                  state_d = ST_FILL;
               end else if (cond_op && i_cond_true) begin
                  fill_d = `IFD_CYC_ONE;
                  state_d = ST_FILL;
               end
            end
         end
         ST_EXT: begin
            // A flushed extension is the last cycle of a skip; no fill cycle follows it.
            if (take) begin
               state_d = ST_DECODE;
               skip_two_d = 1'b0;
            end
         end
         ST_FILL: begin
            fill_d = fill_q - `IFD_CYC_ONE;
            if (fill_q == `IFD_CYC_ONE) begin
               state_d = ST_DECODE;
            end
         end
         ST_SKIP: begin
            // Skipped word is flushed; a two-word target also flushes its extension.
            if (take) begin
               if (two_word) begin
                  state_d = ST_EXT;
                  skip_two_d = 1'b1;
                  fill_d = 2'h0;
               end else begin
                  state_d = ST_DECODE;
               end
            end
         end
         default: begin
            state_d = ST_DECODE;
         end
      endcase
   end

   always @(posedge i_mclk) begin
      if (i_reset) begin
         state_q <= ST_DECODE;
         fill_q <= 2'h0;
         skip_two_q <= 1'b0;
         o_exec_valid_q <= 1'b0;
         o_exec_nop_q <= 1'b0;
         o_second_word_q <= 1'b0;
         o_opcode_q <= `IFD_OPC_NOP;
         o_operand_q <= 16'h0000;
         o_extension_q <= 16'h0000;
         o_category_q <= `IFD_CAT_NOP;
         o_cycles_q <= 2'h0;
         o_format_error_q <= 1'b0;
      end else begin
         state_q <= state_d;
         fill_q <= fill_d;
         skip_two_q <= skip_two_d;
         o_exec_valid_q <= 1'b1;
         o_second_word_q <= 1'b0;
         o_format_error_q <= 1'b0;
         if (state_q == ST_DECODE && take) begin
            o_opcode_q <= opc;
            o_operand_q <= i_fetch_word[15:0];
            o_category_q <= cat;
            o_exec_nop_q <= (cat == `IFD_CAT_NOP);
            if (two_word) begin
               o_cycles_q <= `IFD_CYC_TWO;
            end else if (skip_op && i_skip_taken) begin
               o_cycles_q <= `IFD_CYC_TWO;
            end else if (long_op) begin
               o_cycles_q <= LONG_OP_CYCLES;
            end else if (cond_op && i_cond_true) begin
               o_cycles_q <= `IFD_CYC_TWO;
            end else begin
               o_cycles_q <= `IFD_CYC_ONE;
            end
         end else if (state_q == ST_EXT && take) begin
            o_extension_q <= i_fetch_word[15:0];
            o_second_word_q <= 1'b1;
            o_exec_nop_q <= skip_two_q;
            o_format_error_q <= (opc != 8'h00);
         end else if (state_q == ST_SKIP && take) begin
            o_exec_nop_q <= 1'b1;
            if (two_word) begin
               o_cycles_q <= `IFD_CYC_THREE;
            end
         end else begin
            // Fill cycles execute as no-operations; idle cycles are flagged no-op but not valid.
            o_exec_nop_q <= 1'b1;
            o_exec_valid_q <= take | state_q[2];
         end
      end
   end

endmodule

// ==== hdl/ifd_consts.vh ====
/*
 Instruction format and cycle-timing constants for the instruction decoder.
 Assumes inclusion by bare name from the decoder files.
*/
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH

// =============================================================
// Word layout
`define IFD_WORD_W 24
`define IFD_OPC_HI 23
`define IFD_OPC_LO 16
`define IFD_OPC_W 8
`define IFD_OPD_W 16

// =============================================================
// Opcode classes (arbitrary encoding of the opcode field)
`define IFD_OPC_NOP 8'h00
`define IFD_OPC_GOTO 8'h04
`define IFD_OPC_CALL 8'h02
`define IFD_OPC_DMOV 8'hbe
`define IFD_OPC_BRANCH 8'h37
`define IFD_OPC_BRANCH_CMP 8'h01
`define IFD_OPC_IND_JMP 8'h05
`define IFD_OPC_TBL_LO 8'hba
`define IFD_OPC_TBL_HI 8'hbb
`define IFD_OPC_RET 8'h06
`define IFD_OPC_RETI 8'h07
`define IFD_OPC_SKIP_LO 8'ha4
`define IFD_OPC_SKIP_HI 8'ha7
`define IFD_OPC_CBR_LO 8'h30
`define IFD_OPC_CBR_HI 8'h36
`define IFD_OPC_WORK_LO 8'h40
`define IFD_OPC_WORK_HI 8'h7f
`define IFD_OPC_FREG_LO 8'hb0
`define IFD_OPC_FREG_HI 8'hb7
`define IFD_OPC_BIT_LO 8'ha0
`define IFD_OPC_BIT_HI 8'ha3
`define IFD_OPC_LIT_LO 8'hb8
`define IFD_OPC_LIT_HI 8'hb9

// =============================================================
// Category codes
`define IFD_CAT_W 3
`define IFD_CAT_WORK 3'h0
`define IFD_CAT_FREG 3'h1
`define IFD_CAT_BIT 3'h2
`define IFD_CAT_LIT 3'h3
`define IFD_CAT_CTRL 3'h4
`define IFD_CAT_NOP 3'h5

// =============================================================
// Cycle counts
`define IFD_CYC_W 2
`define IFD_CYC_ONE 2'h1
`define IFD_CYC_TWO 2'h2
`define IFD_CYC_THREE 2'h3
`define IFD_CYC_LONG_DEF 2'h2

`endif

// ==== hdl/ifd_class.v ====
/*
 Combinational opcode classifier: category, word count and long, skip, conditional and table flags.
 Assumes the opcode of the unregistered word offered on the fetch port at its input.
*/
`timescale 1ns/1ps
`include "ifd_consts.vh"

module ifd_class (
   input wire [7:0] i_opcode,
   output reg [2:0] o_category,
   output reg o_two_word,
   output reg o_long_op,
   output reg o_skip_op,
   output reg o_cond_op,
   output reg o_table_op
);

   function in_range;
      input [7:0] v;
      input [7:0] lo;
      input [7:0] hi;
      begin
         in_range = (v >= lo) && (v <= hi);
      end
   endfunction

   always @* begin
      o_two_word = (i_opcode == `IFD_OPC_GOTO) || (i_opcode == `IFD_OPC_CALL)
         || (i_opcode == `IFD_OPC_DMOV);
      o_table_op = in_range(i_opcode, `IFD_OPC_TBL_LO, `IFD_OPC_TBL_HI);
      o_long_op = (i_opcode == `IFD_OPC_BRANCH) || (i_opcode == `IFD_OPC_BRANCH_CMP)
         || (i_opcode == `IFD_OPC_IND_JMP) || o_table_op
         || (i_opcode == `IFD_OPC_RET) || (i_opcode == `IFD_OPC_RETI);
      o_skip_op = in_range(i_opcode, `IFD_OPC_SKIP_LO, `IFD_OPC_SKIP_HI);
      o_cond_op = in_range(i_opcode, `IFD_OPC_CBR_LO, `IFD_OPC_CBR_HI);
      if (i_opcode == `IFD_OPC_NOP) begin
         o_category = `IFD_CAT_NOP;
      end else if (in_range(i_opcode, `IFD_OPC_WORK_LO, `IFD_OPC_WORK_HI)) begin
         o_category = `IFD_CAT_WORK;
      end else if (in_range(i_opcode, `IFD_OPC_FREG_LO, `IFD_OPC_FREG_HI)) begin
         o_category = `IFD_CAT_FREG;
      end else if (o_skip_op || in_range(i_opcode, `IFD_OPC_BIT_LO, `IFD_OPC_BIT_HI)) begin
         o_category = `IFD_CAT_BIT;
      end else if (in_range(i_opcode, `IFD_OPC_LIT_LO, `IFD_OPC_LIT_HI)) begin
         o_category = `IFD_CAT_LIT;
      end else begin
         o_category = `IFD_CAT_CTRL;
      end
   end

endmodule

// ==== hdl/ifd_fields.v ====
/*
 Operand field extractor for a single 24-bit instruction word.
 Assumes the category comes from the classifier for the same word.
*/
`timescale 1ns/1ps
`include "ifd_consts.vh"

module ifd_fields (
   input wire [23:0] i_word,
   input wire [2:0] i_category,
   output reg [3:0] o_base_source_register,
   output reg [3:0] o_second_source_register,
   output reg [2:0] o_second_source_mode,
   output reg [3:0] o_destination_register,
   output reg [2:0] o_destination_mode,
   output reg [12:0] o_file_addr,
   output reg o_dest_is_working_register_zero,
   output reg [3:0] o_bit_pos,
   output reg o_bit_from_base,
   output reg [9:0] o_literal,
   output reg o_dest_separate,
   output reg [15:0] o_prog_addr,
   output reg [1:0] o_table_mode
);

   always @* begin
      o_base_source_register = i_word[14:11];
      o_second_source_register = i_word[3:0];
      o_second_source_mode = 3'h0;
      o_destination_register = i_word[10:7];
      o_destination_mode = 3'h0;
      o_file_addr = 13'h0000;
      o_dest_is_working_register_zero = 1'b0;
      o_bit_pos = 4'h0;
      o_bit_from_base = 1'b0;
      o_literal = 10'h000;
      o_dest_separate = 1'b0;
      o_prog_addr = 16'h0000;
      o_table_mode = 2'h0;
      case (i_category)
         `IFD_CAT_WORK: begin
            // Base source never carries a modifier; the other two do.
            o_second_source_mode = i_word[6:4];
            o_destination_mode = {i_word[15], i_word[5:4]};
         end
         `IFD_CAT_FREG: begin
            o_file_addr = i_word[12:0];
            o_dest_is_working_register_zero = i_word[13];
         end
         `IFD_CAT_BIT: begin
            o_second_source_mode = i_word[6:4];
            o_file_addr = i_word[12:0];
            o_bit_from_base = i_word[15];
            o_bit_pos = i_word[15] ? 4'h0 : i_word[14:11];
         end
         `IFD_CAT_LIT: begin
            o_literal = i_word[9:0];
            o_dest_separate = i_word[15];
            o_destination_mode = i_word[15] ? {1'b0, i_word[6:5]} : 3'h0;
         end
         `IFD_CAT_CTRL: begin
            o_prog_addr = i_word[15:0];
            o_table_mode = i_word[15:14];
         end
         default: begin
            o_second_source_mode = 3'h0;
         end
      endcase
   end

endmodule

// ==== testbench/ifd_decoder_assertions.sv ====
/*
 Checker for the decoder: fill cycles, word pairing, flushes and no-ops.
 Assumes it is bound to every decoder and sees only its ports.
*/
`timescale 1ns/1ps
module ifd_decoder_chk #(
   parameter [1:0] LONG_OP_CYCLES = 2'h2
) (
   input wire i_mclk,
   input wire i_reset,
   input wire [23:0] i_fetch_word,
   input wire i_fetch_valid,
   input wire o_fetch_ready,
   input wire i_cond_true,
   input wire i_skip_taken,
   input wire o_exec_valid_q,
   input wire o_exec_nop_q,
   input wire o_second_word_q,
   input wire [2:0] o_category_q,
   input wire [1:0] o_cycles_q,
   input wire o_format_error_q
);
   // ==========================================================
   // Word tracking
   wire [7:0] op = i_fetch_word[23:16];
   wire tk = i_fetch_valid && o_fetch_ready;
   reg sec_q;
   reg fl_q;
   reg [1:0] low_q;
   wire first = tk && !sec_q && !fl_q;
   wire two = op == 8'h04 || op == 8'h02 || op == 8'hbe;
   wire lng = op == 8'h37 || op == 8'h01 || op == 8'h05 || op == 8'hba || op == 8'hbb
      || op == 8'h06 || op == 8'h07;
   wire cbr = op >= 8'h30 && op <= 8'h36;
   wire skp = op >= 8'ha4 && op <= 8'ha7;
   wire wrg = op >= 8'h40 && op <= 8'h7f;
   // A flushed two-word target drags its extension into the flush as well.
   always @(posedge i_mclk) begin
      if (i_reset) begin
         sec_q <= 1'b0;
         fl_q <= 1'b0;
         low_q <= 2'h0;
      end else begin
         if (tk) begin
            sec_q <= first && two;
            fl_q <= (first && skp && i_skip_taken) || (fl_q && two);
         end
         low_q <= o_fetch_ready ? 2'h0 : low_q + 2'h1;
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   AST_WORKING_REGISTER_ZERO_ONE:
      assert property (first && wrg |=> o_cycles_q == 2'h1 && o_fetch_ready && !o_exec_nop_q
         && o_category_q == 3'h0) else $error("register op timing wrong");
   AST_LONG_FILL:
      assert property (first && lng |=> o_cycles_q == LONG_OP_CYCLES && !o_fetch_ready)
      else $error("long op timing wrong");
   AST_FILL_LEN:
      assert property ($rose(o_fetch_ready) && o_cycles_q != 2'h0 |-> low_q == o_cycles_q - 2'h1)
      else $error("fill count wrong");
   AST_FILL_NOP:
      assert property (!o_fetch_ready |=> o_exec_valid_q && o_exec_nop_q)
      else $error("fill not a no-op");
   AST_COND_TAKEN:
      assert property (first && cbr && i_cond_true |=> o_cycles_q == 2'h2 && !o_fetch_ready
         ##1 o_fetch_ready) else $error("taken condition timing wrong");
   AST_TWO_WORD:
      assert property (first && two |=> o_cycles_q == 2'h2 && o_fetch_ready)
      else $error("two-word timing wrong");
   AST_SECOND_OK:
      assert property (tk && sec_q && op == 8'h00 |=> o_second_word_q && !o_format_error_q)
      else $error("second word not accepted");
   AST_SECOND_BAD:
      assert property (tk && sec_q && op != 8'h00 |=> o_format_error_q)
      else $error("bad second word not flagged");
   AST_BARE_NOP:
      assert property (first && op == 8'h00 |=> o_exec_nop_q && o_category_q == 3'h5)
      else $error("bare second word not a no-op");
   AST_SKIP:
      assert property (first && skp && i_skip_taken |=> o_cycles_q == 2'h2)
      else $error("skip timing wrong");
   AST_FLUSH:
      assert property (tk && fl_q |=> o_exec_valid_q && o_exec_nop_q)
      else $error("skipped word executed");
   AST_SKIP_TWO:
      assert property (tk && fl_q && two |=> o_cycles_q == 2'h3 && o_fetch_ready
         ##1 o_fetch_ready) else $error("skip over two-word timing wrong");
   cover property (first && lng);
   cover property (tk && fl_q && two);
   cover property (tk && sec_q && op != 8'h00);
endmodule

bind ifd_decoder ifd_decoder_chk #(.LONG_OP_CYCLES(LONG_OP_CYCLES)) i_ifd_decoder_chk (
   .i_mclk, .i_reset, .i_fetch_word, .i_fetch_valid, .o_fetch_ready, .i_cond_true,
   .i_skip_taken, .o_exec_valid_q, .o_exec_nop_q, .o_second_word_q, .o_category_q,
   .o_cycles_q, .o_format_error_q);

// ==== testbench/ifd_pmem_model.sv ====
/*
 Program memory model: offers queued words on the valid/ready handshake.
 Assumes the bench fills the queue; each entry also carries the datapath
 condition and skip outcome that belong to that word.
*/
`timescale 1ns/1ps
module ifd_pmem_model (
   input wire i_mclk,
   input wire i_reset,
   input wire i_ready,
   input wire i_stall_en,
   output reg [23:0] o_word = 24'h000000,
   output reg o_valid = 1'b0,
   output reg o_cond = 1'b0,
   output reg o_skip = 1'b0
);
   reg [25:0] q [$];
   integer n_tk = 0;
   integer n_off = 0;
   task push(input [25:0] v);
      q.push_back(v);
   endtask
   always @(posedge i_mclk) begin
      if (o_valid && i_ready && !i_reset) n_tk <= n_tk + 1;
   end
   // Idle lines toggle every cycle so a stale word can never pass as fresh.
   always @(negedge i_mclk) begin
      if (i_reset) begin
         o_valid <= 1'b0;
         n_off <= n_tk;
      end else if (n_tk == n_off) begin
         if (q.size() > 0 && !(i_stall_en && $urandom % 3 == 0)) begin
            {o_skip, o_cond, o_word} <= q.pop_front();
            o_valid <= 1'b1;
            n_off <= n_off + 1;
         end else begin
            o_valid <= 1'b0;
            {o_skip, o_cond, o_word} <= ~{o_skip, o_cond, o_word};
         end
      end
   end
endmodule

// ==== testbench/tb_ifd_decoder.sv ====
/*
 Self-checking bench for the decoder against a memory model.
 Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
module tb_ifd_decoder;
   localparam [1:0] LONG = 2'h3;
   reg i_mclk = 1'b0;
   reg i_reset = 1'b1;
   reg stall_en = 1'b0;
   wire [23:0] i_fetch_word;
   wire i_fetch_valid, o_fetch_ready, i_cond_true, i_skip_taken, o_exec_valid_q;
   wire o_exec_nop_q, o_second_word_q, o_format_error_q;
   wire [7:0] o_opcode_q;
   wire [2:0] o_category_q;
   wire [1:0] o_cycles_q;
   wire [15:0] o_operand_q, o_extension_q, o_prog_addr;
   wire [3:0] o_base_source_register, o_second_source_register;
   wire [3:0] o_destination_register, o_bit_pos;
   wire [2:0] o_second_source_mode, o_destination_mode;
   wire [12:0] o_file_addr;
   wire [9:0] o_literal;
   wire [1:0] o_table_mode;
   wire o_dest_is_working_register_zero, o_bit_from_base, o_dest_separate;
   integer n_mismatch = 0;
   integer n_tests = 0;
   integer fill, exp_fill, i, k;
   reg [23:0] w;
   reg cnd, skp, sec, fl, due;
   reg [15:0] r;
   reg [7:0] ops [0:15];
   always #2 i_mclk = ~i_mclk;
   ifd_decoder #(.LONG_OP_CYCLES(LONG)) i_ifd_decoder (
      .i_mclk, .i_reset, .i_fetch_word, .i_fetch_valid, .o_fetch_ready, .i_cond_true,
      .i_skip_taken, .o_exec_valid_q, .o_exec_nop_q, .o_second_word_q, .o_opcode_q,
      .o_operand_q, .o_extension_q, .o_category_q, .o_cycles_q, .o_format_error_q,
      .o_base_source_register, .o_second_source_register, .o_second_source_mode,
      .o_destination_register, .o_destination_mode, .o_file_addr, .o_literal,
      .o_dest_is_working_register_zero, .o_bit_pos, .o_bit_from_base,
      .o_dest_separate, .o_prog_addr, .o_table_mode);
   ifd_pmem_model i_ifd_pmem_model (.i_mclk, .i_reset, .i_ready(o_fetch_ready),
      .i_stall_en(stall_en), .o_word(i_fetch_word), .o_valid(i_fetch_valid),
      .o_cond(i_cond_true), .o_skip(i_skip_taken));
   // ==========================================================
   // Reference model
   function two(input [7:0] op);
      two = op == 8'h04 || op == 8'h02 || op == 8'hbe;
   endfunction
   function lng(input [7:0] op);
      lng = op == 8'h37 || op == 8'h01 || op == 8'h05 || op == 8'hba || op == 8'hbb
         || op == 8'h06 || op == 8'h07;
   endfunction
   function skipop(input [7:0] op);
      skipop = op >= 8'ha4 && op <= 8'ha7;
   endfunction
   function [1:0] ecyc(input [7:0] op, input c, input s);
      if (two(op) || (op >= 8'h30 && op <= 8'h36 && c) || (skipop(op) && s)) ecyc = 2'h2;
      else if (lng(op)) ecyc = LONG;
      else ecyc = 2'h1;
   endfunction
   function [2:0] ecat(input [7:0] op);
      if (op == 8'h00) ecat = 3'h5;
      else if (op >= 8'h40 && op <= 8'h7f) ecat = 3'h0;
      else if (op >= 8'hb0 && op <= 8'hb7) ecat = 3'h1;
      else if (op >= 8'ha0 && op <= 8'ha3) ecat = 3'h2;
      else if (op == 8'hb8 || op == 8'hb9) ecat = 3'h3;
      else if (lng(op) || op == 8'h04 || op == 8'h02) ecat = 3'h4;
      else ecat = 3'h7;
   endfunction
   task chk_val(input [15:0] g, input [15:0] e);
      n_tests = n_tests + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task chk_flag(input g, input e);
      chk_val({15'h0000, g}, {15'h0000, e});
   endtask
   task put(input [7:0] op, input c, input s);
      r = $urandom;
      i_ifd_pmem_model.push({s, c, op, r});
      r = $urandom;
      if (two(op)) i_ifd_pmem_model.push({10'h000, r});
   endtask
   task drain;
      k = 0;
      while ((i_ifd_pmem_model.q.size() != 0 || i_fetch_valid) && k < 5000) begin
         @(negedge i_mclk);
         k = k + 1;
      end
      if (k == 5000) n_mismatch = n_mismatch + 1;
      repeat (4) @(negedge i_mclk);
   endtask
   task final_report;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========================================================
   // Scoreboard
   always @(posedge i_mclk) begin
      if (i_reset) begin
         {sec, fl, due} = 3'h0;
         fill = 0;
         exp_fill = 0;
      end else begin
         if (!o_fetch_ready) fill = fill + 1;
         if (i_fetch_valid && o_fetch_ready) {due, skp, cnd, w} = {1'b1, i_skip_taken,
            i_cond_true, i_fetch_word};
      end
   end
   always @(negedge i_mclk) begin
      if (due) begin
         due = 1'b0;
         if (sec) begin
            chk_flag(o_second_word_q, 1'b1);
            chk_flag(o_format_error_q, w[23:16] != 8'h00);
            chk_val(o_extension_q, w[15:0]);
            sec = 1'b0;
         end else if (fl) begin
            chk_flag(o_exec_nop_q, 1'b1);
            if (two(w[23:16])) chk_val(o_cycles_q, 2'h3);
            fl = two(w[23:16]);
         end else begin
            chk_val(fill[15:0], exp_fill[15:0]);
            chk_val(o_opcode_q, w[23:16]);
            chk_val(o_operand_q, w[15:0]);
            chk_val(o_base_source_register, w[14:11]);
            if (ecat(w[23:16]) == 3'h0) begin
               chk_val(o_second_source_register, w[3:0]);
               chk_val(o_second_source_mode, w[6:4]);
               chk_val(o_destination_register, w[10:7]);
               chk_val(o_destination_mode, {w[15], w[5:4]});
            end
            if (ecat(w[23:16]) == 3'h1) begin
               chk_val(o_file_addr, w[12:0]);
               chk_flag(o_dest_is_working_register_zero, w[13]);
            end
            if (ecat(w[23:16]) == 3'h2) begin
               chk_flag(o_bit_from_base, w[15]);
               chk_val(o_bit_pos, w[15] ? 4'h0 : w[14:11]);
            end
            if (ecat(w[23:16]) == 3'h3) begin
               chk_val(o_literal, w[9:0]);
               chk_flag(o_dest_separate, w[15]);
            end
            if (ecat(w[23:16]) == 3'h4) chk_val(o_prog_addr, w[15:0]);
            if (w[23:17] == 7'h5d) chk_val(o_table_mode, w[15:14]);
            chk_val(o_cycles_q, ecyc(w[23:16], cnd, skp));
            chk_flag(o_exec_nop_q, w[23:16] == 8'h00);
            if (ecat(w[23:16]) != 3'h7) chk_val(o_category_q, ecat(w[23:16]));
            exp_fill = (two(w[23:16]) || skipop(w[23:16])) ? 0 : ecyc(w[23:16], cnd, skp) - 1;
            sec = two(w[23:16]);
            fl = skipop(w[23:16]) && skp;
            fill = 0;
         end
      end
   end
   initial begin
      #(4 * 20000);
      n_mismatch = n_mismatch + 1;
      final_report;
   end
   initial begin
      i = $urandom(45356);
      ops = '{8'h37, 8'h01, 8'h05, 8'hba, 8'hbb, 8'h06, 8'h07, 8'h04, 8'h02, 8'hbe,
         8'h30, 8'h33, 8'h36, 8'ha4, 8'ha7, 8'h00};
      repeat (6) @(negedge i_mclk);
      chk_val(o_category_q, 3'h5);
      chk_flag(o_exec_valid_q, 1'b0);
      i_reset = 1'b0;
      for (i = 0; i < 16; i = i + 1) put(ops[i], 1'b1, 1'b0);
      put(8'h36, 1'b0, 1'b1);
      put(8'ha4, 1'b0, 1'b1);
      put(8'h45, 1'b0, 1'b0);
      put(8'ha7, 1'b0, 1'b1);
      put(8'h04, 1'b0, 1'b0);
      put(8'ha1, 1'b0, 1'b0);
      put(8'hb3, 1'b0, 1'b0);
      put(8'hb8, 1'b0, 1'b0);
      i_ifd_pmem_model.push({10'h002, 16'h1234});
      i_ifd_pmem_model.push({10'h05a, 16'h0000});
      put(8'h40, 1'b0, 1'b0);
      drain;
      stall_en = 1'b1;
      for (i = 0; i < 200; i = i + 1) begin
         r = $urandom;
         put(r[15] ? ops[r[3:0]] : {2'b01, r[9:4]}, r[10], r[11]);
      end
      drain;
      final_report;
   end
endmodule
